// file: verilog/sat_spi_params.svh
// Constants for the satellite SPI frame: layout, field positions, timing.
// Assumes the includer has a 100 MHz pclk.
`ifndef SAT_SPI_PARAMS_SVH
`define SAT_SPI_PARAMS_SVH
`define WORD_BITS 16
`define FRAME_WORDS 5
`define FRAME_BITS 80
`define CNT_W 7
`define W_MSB 15
// Command and response word fields
`define CCR_SEL_BIT 14
`define CCR_WR_BIT 13
`define MCR_KEEP_MASK 16'h3FFC
`define MCR_PROTO_HI 13
`define MCR_PROTO_LO 10
`define MCR_SYNC_HI 9
`define MCR_SYNC_LO 8
`define MCR_AUXA_EN 7
`define MCR_AUXB_EN 6
`define MCR_AUXA_SEL 5
`define MCR_AUXB_SEL 4
`define MCR_FAMILY 3
`define MCR_RXD 2
`define SR_TAG 16'h4000
`define SR_FAULT_W 9
// Timing in microseconds, clock rate and time field width
`define CLK_MHZ 100
`define SYNC_US_00 20
`define SYNC_US_01 30
`define SYNC_US_10 40
`define SYNC_US_11 80
`define RXD_FIXED_US 62
`define RXD_EXTRA_US 20
`define TIME_W 14
// Host register byte offsets and default sclk half-period count
`define HOST_CTRL 8'h00
`define HOST_STATUS 8'h04
`define HOST_TX0 8'h08
`define HOST_RX0 8'h1C
`define HOST_WORD_STEP 8'h04
`define HOST_HALF_DEF 10
`endif

// file: verilog/sat_spi_pkg.sv
// Types for the satellite SPI link: word_t for both ends, host_state_e for the host end.
// Assumes nothing beyond a SystemVerilog compiler.
package sat_spi_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP = 3'b101
  } host_state_e;
endpackage

// file: verilog/sat_spi_if.sv
// Four-wire satellite SPI link between host and device.
// Assumes the bench connects both modports; miso idles high when undriven.
interface sat_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport device (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// file: verilog/sat_spi_device.sv
// Device end: 80-bit satellite frame, module config word, aux pin control.
// Assumes link pins are asynchronous to pclk and the SPI clock idles low.
`include "sat_spi_params.svh"
module sat_spi_device
  import sat_spi_pkg::*;
#(
  parameter int unsigned SYNC_CYC_00 = `SYNC_US_00 * `CLK_MHZ,
  parameter int unsigned SYNC_CYC_01 = `SYNC_US_01 * `CLK_MHZ,
  parameter int unsigned SYNC_CYC_10 = `SYNC_US_10 * `CLK_MHZ,
  parameter int unsigned SYNC_CYC_11 = `SYNC_US_11 * `CLK_MHZ,
  parameter int unsigned RXD_FIXED_CYC = `RXD_FIXED_US * `CLK_MHZ,
  parameter int unsigned RXD_EXTRA_CYC = `RXD_EXTRA_US * `CLK_MHZ
)
(
  input wire logic pclk,
  input wire logic presetn,
  sat_spi_if.device link,
  input wire logic [63:0] chan_data,
  input wire logic [`SR_FAULT_W-1:0] sat_fault,
  input wire logic [1:0] ch_above_thr,
  input wire logic [1:0] ch_on,
  output logic [15:0] module_config_word,
  output logic [63:0] channel_config,
  output logic [`TIME_W-1:0] sync_high_cycles,
  output logic [`TIME_W-1:0] rx_disable_cycles,
  output logic [1:0] aux_out_pin_o,
  output logic [1:0] aux_out_pin_oe,
  output logic [1:0] aux_analog_en,
  output logic frame_done
);

  function automatic word_t fix_lo(input word_t w);
    fix_lo = {w[15:1], ~^w[15:1]};
  endfunction

  function automatic word_t fix_hi(input word_t w);
    fix_hi = {~^w[14:0], w[14:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change accepted when stages two and three agree
  logic [2:0] s_sclk, s_cs, s_mosi;
  logic f_sclk, f_cs_n, f_mosi;
  logic d_sclk, d_cs_n;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_sclk <= 3'h0;
      s_cs <= 3'h7;
      s_mosi <= 3'h0;
    end
    else
    begin
      s_sclk <= {s_sclk[1:0], link.sclk};
      s_cs <= {s_cs[1:0], link.cs_n};
      s_mosi <= {s_mosi[1:0], link.mosi};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      f_sclk <= 1'b0;
      f_cs_n <= 1'b1;
      f_mosi <= 1'b0;
      d_sclk <= 1'b0;
      d_cs_n <= 1'b1;
    end
    else
    begin
      if (s_sclk[1] == s_sclk[2])
        f_sclk <= s_sclk[2];
      if (s_cs[1] == s_cs[2])
        f_cs_n <= s_cs[2];
      if (s_mosi[1] == s_mosi[2])
        f_mosi <= s_mosi[2];
      d_sclk <= f_sclk;
      d_cs_n <= f_cs_n;
    end
  end

  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall = d_cs_n && !f_cs_n;
  assign cs_rise = !d_cs_n && f_cs_n;
  assign sck_rise = !f_cs_n && !d_sclk && f_sclk;
  assign sck_fall = !f_cs_n && d_sclk && !f_sclk;

  ////////////////////////////////////////////////////////////////////////
  // Shifting
  logic [`FRAME_BITS-1:0] rx_sh, tx_sh, next_tx;
  logic [`CNT_W-1:0] bit_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sh <= '0;
      bit_cnt <= '0;
    end
    else if (cs_fall)
      bit_cnt <= '0;
    else if (sck_rise)
    begin
      rx_sh <= {rx_sh[`FRAME_BITS-2:0], f_mosi};
      if (bit_cnt <= `CNT_W'(`FRAME_BITS))
        bit_cnt <= bit_cnt + `CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_sh <= '0;
    else if (cs_fall)
      tx_sh <= next_tx;
    else if (sck_fall)
      tx_sh <= {tx_sh[`FRAME_BITS-2:0], 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.miso_o <= 1'b1;
      link.miso_oe <= 1'b0;
    end
    else
    begin
      link.miso_o <= tx_sh[`FRAME_BITS-1];
      link.miso_oe <= !f_cs_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame commit at deselect
  word_t cmd [`FRAME_WORDS];
  logic [`FRAME_WORDS-1:0] par_ok;
  logic frame_ok;
  for (genvar i = 0; i < `FRAME_WORDS; i++)
  begin : g_word
    assign cmd[i] = rx_sh[`FRAME_BITS-1-i*`WORD_BITS -: `WORD_BITS];
    assign par_ok[i] = ^cmd[i];
  end
  assign frame_ok = bit_cnt == `CNT_W'(`FRAME_BITS);

  logic [3:0] was_ccr;
  logic err_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      module_config_word <= '0;
      channel_config <= '0;
      was_ccr <= 4'hF;
      err_prev <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= cs_rise;
      if (cs_rise)
      begin
        err_prev <= !frame_ok || !(&par_ok);
        if (frame_ok)
        begin
          if (par_ok[0])
            module_config_word <= cmd[0] & `MCR_KEEP_MASK;
          for (int c = 0; c < 4; c++)
          begin
            was_ccr[c] <= cmd[c+1][`CCR_SEL_BIT];
            if (par_ok[c+1] && cmd[c+1][`CCR_SEL_BIT] && cmd[c+1][`CCR_WR_BIT])
              channel_config[c*`WORD_BITS +: `WORD_BITS] <= cmd[c+1];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response assembly for the next frame
  logic [3:0] kind_hold;
  word_t resp [`FRAME_WORDS];
  word_t status_w;
  logic any_data;

  assign any_data = !(&was_ccr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      kind_hold <= 4'h0;
    else if (cs_fall && any_data)
      kind_hold <= ~was_ccr;
  end

  always_comb
  begin
    status_w = fix_lo({err_prev, 1'b0, any_data ? ~was_ccr : kind_hold, sat_fault, 1'b0})
               | `SR_TAG;
    status_w[0] = ~^status_w[15:1];
    if (any_data)
      resp[0] = status_w;
    else
      resp[0] = fix_lo({err_prev, module_config_word[14:0]});
    for (int c = 0; c < 4; c++)
    begin
      if (was_ccr[c])
        resp[c+1] = fix_hi({1'b0, 1'b1, channel_config[c*`WORD_BITS +: 14]});
      else
        resp[c+1] = chan_data[c*`WORD_BITS +: `WORD_BITS];
    end
    if (!(&was_ccr[2:0]))
      resp[4] = status_w;
    next_tx = {resp[0], resp[1], resp[2], resp[3], resp[4]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_high_cycles <= `TIME_W'(SYNC_CYC_00);
    else
      unique case (module_config_word[`MCR_SYNC_HI:`MCR_SYNC_LO])
        2'b00: sync_high_cycles <= `TIME_W'(SYNC_CYC_00);
        2'b01: sync_high_cycles <= `TIME_W'(SYNC_CYC_01);
        2'b10: sync_high_cycles <= `TIME_W'(SYNC_CYC_10);
        2'b11: sync_high_cycles <= `TIME_W'(SYNC_CYC_11);
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_disable_cycles <= `TIME_W'(RXD_FIXED_CYC);
    else if (module_config_word[`MCR_RXD])
      rx_disable_cycles <= sync_high_cycles + `TIME_W'(RXD_EXTRA_CYC);
    else
      rx_disable_cycles <= `TIME_W'(RXD_FIXED_CYC);
  end

  logic [1:0] aux_en, aux_sel;
  assign aux_en = {module_config_word[`MCR_AUXB_EN], module_config_word[`MCR_AUXA_EN]};
  assign aux_sel = {module_config_word[`MCR_AUXB_SEL], module_config_word[`MCR_AUXA_SEL]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_out_pin_o <= 2'h0;
      aux_out_pin_oe <= 2'h0;
      aux_analog_en <= 2'h0;
    end
    else
    begin
      aux_out_pin_oe <= aux_en & aux_sel;
      aux_analog_en <= aux_en & ~aux_sel;
      aux_out_pin_o <= ~(ch_on & ch_above_thr);
    end
  end

endmodule

// file: verilog/sat_spi_host.sv
// Host end: APB-programmed master that runs one 80-bit satellite frame.
// Assumes an APB master on pclk and a device that answers on miso.
`include "sat_spi_params.svh"
module sat_spi_host
  import sat_spi_pkg::*;
#(
  parameter int unsigned HALF_CYC = `HOST_HALF_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  sat_spi_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  function automatic int word_index(input logic [7:0] a, input logic [7:0] base);
    word_index = int'((a - base) / `HOST_WORD_STEP);
  endfunction

  word_t tx_word [`FRAME_WORDS];
  logic [`FRAME_BITS-1:0] tx_sh, rx_sh;
  logic [`CNT_W-1:0] bits;
  logic [15:0] tcnt;
  logic [2:0] s_miso;
  logic f_miso;
  logic busy;
  host_state_e state;
  logic wr_acc, rd_acc, start;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign start = wr_acc && paddr == `HOST_CTRL && pwdata[0] && state == H_IDLE;
  assign busy = state != H_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= '0;
      for (int i = 0; i < `FRAME_WORDS; i++)
        tx_word[i] <= '0;
    end
    else
    begin
      if (wr_acc && paddr >= `HOST_TX0 && paddr < `HOST_RX0 && paddr[1:0] == 2'h0)
        tx_word[word_index(paddr, `HOST_TX0)] <= pwdata[15:0];
      if (rd_acc)
      begin
        prdata <= '0;
        if (paddr == `HOST_STATUS)
          prdata <= {31'h0, busy};
        else if (paddr >= `HOST_TX0 && paddr < `HOST_RX0 && paddr[1:0] == 2'h0)
          prdata <= {16'h0, tx_word[word_index(paddr, `HOST_TX0)]};
        else if (paddr >= `HOST_RX0 && paddr[1:0] == 2'h0
                 && word_index(paddr, `HOST_RX0) < `FRAME_WORDS)
          prdata <= {16'h0, rx_sh[`FRAME_BITS-1-word_index(paddr, `HOST_RX0)*`WORD_BITS
                                  -: `WORD_BITS]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Miso synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_miso <= 3'h7;
      f_miso <= 1'b1;
    end
    else
    begin
      s_miso <= {s_miso[1:0], link.miso};
      if (s_miso[1] == s_miso[2])
        f_miso <= s_miso[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= H_IDLE;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
      tx_sh <= '0;
      rx_sh <= '0;
      bits <= '0;
      tcnt <= '0;
    end
    else
    begin
      tcnt <= tcnt + 16'h0001;
      unique case (state)
        H_IDLE:
          if (start)
          begin
            tx_sh <= {tx_word[0][15:1], ~^tx_word[0][15:1],
                      ~^tx_word[1][14:0], tx_word[1][14:0],
                      ~^tx_word[2][14:0], tx_word[2][14:0],
                      ~^tx_word[3][14:0], tx_word[3][14:0],
                      ~^tx_word[4][14:0], tx_word[4][14:0]};
            link.cs_n <= 1'b0;
            bits <= '0;
            tcnt <= '0;
            state <= H_LEAD;
          end
        H_LEAD:
        begin
          link.mosi <= tx_sh[`FRAME_BITS-1];
          state <= H_LOW;
        end
        H_LOW:
          if (tcnt >= 16'(HALF_CYC))
          begin
            link.sclk <= 1'b1;
            rx_sh <= {rx_sh[`FRAME_BITS-2:0], f_miso};
            tcnt <= '0;
            state <= H_HIGH;
          end
        H_HIGH:
          if (tcnt >= 16'(HALF_CYC))
          begin
            link.sclk <= 1'b0;
            tx_sh <= {tx_sh[`FRAME_BITS-2:0], 1'b0};
            link.mosi <= tx_sh[`FRAME_BITS-2];
            bits <= bits + `CNT_W'(1);
            tcnt <= '0;
            state <= (bits == `CNT_W'(`FRAME_BITS - 1)) ? H_TAIL : H_LOW;
          end
        H_TAIL:
          if (tcnt >= 16'(HALF_CYC))
          begin
            link.cs_n <= 1'b1;
            link.mosi <= 1'b0;
            tcnt <= '0;
            state <= H_GAP;
          end
        H_GAP:
          if (tcnt >= 16'(2 * HALF_CYC))
            state <= H_IDLE;
        default:
          state <= H_IDLE;
      endcase
    end
  end

endmodule

// file: test/sat_spi_monitor.sv
// Checker for the satellite SPI wires between the host and device ends.
// Assumes every wire comes from a flop on pclk; sits beside the link.
module sat_spi_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [6:0] bits;
  ////////////////////////////////////////////////////////////////////////////////
  // Edge memory and bit count within a frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bits <= 7'd0;
    else if (cs_n)
      bits <= 7'd0;
    else if (sclk && !sclk_q)
      bits <= bits + 7'd1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_frame_bit_count: assert property ($rose(cs_n) |-> bits == 7'd80)
    else $error("frame did not carry 80 bits");
  a_bits_bounded: assert property (!cs_n |-> bits <= 7'd80)
    else $error("more than 80 clocks in a frame");
  a_select_lead: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("sclk rose too soon after select");
  a_select_hold: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select released too soon");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("frames too close together");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*8])
    else $error("sclk high phase too short");
  a_sclk_low_time: assert property ($fell(sclk) && !cs_n |-> !sclk [*8])
    else $error("sclk low phase too short");
  a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_held: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
endmodule

// file: test/satellite_spi_frame_config_test.sv
// Bench: host and device ends joined over the link, host driven over APB.
// Assumes design files, package and link interface compile first.
`include "sat_spi_params.svh"
module satellite_spi_frame_config_test;
  import sat_spi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SYNC_TAB [4] = '{20, 30, 40, 80};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [63:0] chan_data = 64'h0;
  logic [8:0] sat_fault = 9'h000;
  logic [1:0] ch_above_thr = 2'b00;
  logic [1:0] ch_on = 2'b00;
  logic [15:0] module_config_word;
  logic [63:0] channel_config;
  logic [13:0] sync_high_cycles;
  logic [13:0] rx_disable_cycles;
  logic [1:0] aux_out_pin_o;
  logic [1:0] aux_out_pin_oe;
  logic [1:0] aux_analog_en;
  logic frame_done;
  int n_done = 0;
  int n_fail = 0;
  int checks = 0;
  word_t tx [5];
  word_t rx [5];
  word_t st_ch [4] = '{default: 16'h0000};
  word_t st_cfg = 16'h0000;
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  sat_spi_if u_sat_spi_if ();
  sat_spi_host u_sat_spi_host (.pclk(pclk), .presetn(presetn), .link(u_sat_spi_if.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sat_spi_device #(.SYNC_CYC_00(20), .SYNC_CYC_01(30), .SYNC_CYC_10(40), .SYNC_CYC_11(80),
    .RXD_FIXED_CYC(62)) u_sat_spi_device (.pclk(pclk),
    .presetn(presetn), .link(u_sat_spi_if.device), .chan_data(chan_data),
    .sat_fault(sat_fault), .ch_above_thr(ch_above_thr), .ch_on(ch_on),
    .module_config_word(module_config_word), .channel_config(channel_config),
    .sync_high_cycles(sync_high_cycles), .rx_disable_cycles(rx_disable_cycles),
    .aux_out_pin_o(aux_out_pin_o), .aux_out_pin_oe(aux_out_pin_oe),
    .aux_analog_en(aux_analog_en), .frame_done(frame_done));
  always @(posedge pclk)
    if (frame_done === 1'b1)
      n_done++;
  sat_spi_monitor u_sat_spi_monitor (.pclk(pclk), .presetn(presetn),
    .sclk(u_sat_spi_if.sclk), .cs_n(u_sat_spi_if.cs_n), .mosi(u_sat_spi_if.mosi),
    .miso(u_sat_spi_if.miso));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic word_t p15(input word_t w);
    p15 = {~^w[14:0], w[14:0]};
  endfunction
  function automatic word_t p0(input word_t w);
    p0 = {w[15:1], ~^w[15:1]};
  endfunction
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    check("pslverr", 0, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic frame();
    logic [31:0] q;
    for (int i = 0; i < 5; i++)
      apb(1'b1, `HOST_TX0 + 8'(4 * i), {16'h0, tx[i]}, q);
    apb(1'b1, `HOST_CTRL, 32'h1, q);
    repeat (4) @(posedge pclk);
    do apb(1'b0, `HOST_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, `HOST_RX0 + 8'(4 * i), 32'h0, q);
      rx[i] = q[15:0];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    word_t stat;
    logic [1:0] en;
    logic [1:0] sel;
    void'($urandom(72));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("config after reset", 0, module_config_word);
    check("sync after reset", 20, sync_high_cycles);
    apb(1'b1, 8'hF0, 32'hFFFF_FFFF, q);
    apb(1'b0, 8'hF0, 32'h0, q);
    check("unmapped read", 0, q);
    for (int i = 0; i < 7; i++)
    begin
      tx[0] = 16'($urandom());
      tx[0][9:8] = 2'(i);
      if (tx[0][3])
        tx[0][13:10] = 4'hF;
      for (int c = 1; c < 5; c++)
      begin
        tx[c] = 16'($urandom());
        tx[c][14] = (i != 4);
        tx[c][13] = (i < 4);
      end
      if (i == 4)
      begin
        chan_data <= {$urandom(), $urandom()};
        sat_fault <= 9'($urandom());
      end
      ch_on <= 2'($urandom());
      ch_above_thr <= 2'($urandom());
      frame();
      stat = p0({2'b01, 4'hF, sat_fault, 1'b0});
      if (i == 5)
      begin
        check("status first", stat, rx[0]);
        for (int c = 0; c < 3; c++)
          check("data word", chan_data[16 * c +: 16], rx[c + 1]);
        check("status fifth", stat, rx[4]);
      end
      else if (i > 0)
      begin
        check("config echo", p0(st_cfg), rx[0]);
        for (int c = 0; c < 4; c++)
          check("channel echo", p15({2'b01, st_ch[c][13:0]}), rx[c + 1]);
      end
      st_cfg = tx[0] & `MCR_KEEP_MASK;
      for (int c = 0; c < 4; c++)
        if (tx[c + 1][14] && tx[c + 1][13])
          st_ch[c] = p15(tx[c + 1]);
      repeat (4) @(posedge pclk);
      check("config", st_cfg, module_config_word);
      check("channels", {st_ch[3], st_ch[2], st_ch[1], st_ch[0]}, channel_config);
      check("sync", SYNC_TAB[st_cfg[9:8]], sync_high_cycles);
      check("blank", st_cfg[2] ? SYNC_TAB[st_cfg[9:8]] + `RXD_EXTRA_US * `CLK_MHZ : 62,
        rx_disable_cycles);
      en = {st_cfg[6], st_cfg[7]};
      sel = {st_cfg[4], st_cfg[5]};
      check("aux enable", en & sel, aux_out_pin_oe);
      check("aux analog", en & ~sel, aux_analog_en);
      check("aux level", ~(ch_on & ch_above_thr) & en & sel, aux_out_pin_o & en & sel);
    end
    check("frames done", 7, n_done);
    tally_and_finish();
  end
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
